// ---- hdl/asb_defs.svh ----
// Offsets, opcodes, field positions, sizes and reset values of the command block
`ifndef ASB_DEFS_SVH
`define ASB_DEFS_SVH

// ====================================================================
// Register byte offsets
`define ASB_OFF_DATA      8'h00
`define ASB_OFF_ERRFEAT   8'h04
`define ASB_OFF_SECCNT    8'h08
`define ASB_OFF_SECNUM    8'h0C
`define ASB_OFF_CYLLO     8'h10
`define ASB_OFF_CYLHI     8'h14
`define ASB_OFF_DEVHEAD   8'h18
`define ASB_OFF_CMDSTAT   8'h1C
`define ASB_OFF_APMTMO    8'h20

// ====================================================================
// Opcodes
`define ASB_OP_STBY_IMM_A 8'hE0
`define ASB_OP_STBY_IMM_B 8'h94
`define ASB_OP_BUF_WR     8'hE8
`define ASB_OP_BUF_RD     8'hE4
`define ASB_OP_DMA_WR     7'h65

// ====================================================================
// Status, error and device/head bit positions
`define ASB_ST_BSY        7
`define ASB_ST_RDY        6
`define ASB_ST_DSC        4
`define ASB_ST_DRQ        3
`define ASB_ST_ERR        0
`define ASB_ER_IDN        4
`define ASB_ER_ABT        2
`define ASB_DH_LBA        6

// ====================================================================
// Sizes and reset values
`define ASB_SECT_WORDS    256
`define ASB_CHS_SPT       8'h3F
`define ASB_CHS_HEADS     4'hF
`define ASB_APM_RST       8'h00
`define ASB_DH_RST        8'hA0

`endif

// ---- hdl/asb_pkg.sv ----
// Types shared by the command block
package asb_pkg;

    typedef enum logic [2:0] {
        ASB_IDLE,
        ASB_SPINUP,
        ASB_PIO_WR,
        ASB_PIO_RD,
        ASB_DMA_XFER,
        ASB_DMA_SECT,
        ASB_DONE
    } asb_state_e;

endpackage : asb_pkg

// ---- hdl/asb_cmd.sv ----
// Task-file command interpreter: standby immediate, buffer write/read, DMA write
// Operation
// - Standby-immediate opcode enters standby at once
// - Spin down, interface alive, skip if stopped
// - Standby accepts commands; media waits for spin-up
// - Standby immediate keeps power-down timeout value
// - Buffer write takes exactly one sector
// - Data moves as 16-bit words, one per transfer
// - Buffer write and read share one sector
// - DMA write receives sectors, commits to media
// - Device paces every DMA word with request
// - One completion interrupt after final status
// - Uncorrectable error stops at failing sector
// - Sector count zero means 256 sectors
// - Address as CHS or 28-bit LBA
// - Retry bit of DMA opcode ignored
// - Count returns sectors not transferred
// - Address returns last transferred sector
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`include "asb_defs.svh"

module asb_cmd
    import asb_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // APB register bus
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Host slave-DMA channel
    output logic             dmarq,
    input  wire logic        dmack,
    input  wire logic [15:0] dma_wdata,
    output logic             intrq,
    // Spindle
    output logic             spindle_run,
    input  wire logic        spindle_at_speed,
    // Media write stream
    output logic             media_valid,
    input  wire logic        media_ready,
    output logic      [15:0] media_data,
    input  wire logic        media_sect_done,
    input  wire logic        media_unc
);

    // ================================================================
    // Registers
    asb_state_e  state_r;
    logic [7:0]  feat_r;
    logic [7:0]  seccnt_r;
    logic [7:0]  secnum_r;
    logic [7:0]  cyllo_r;
    logic [7:0]  cylhi_r;
    logic [7:0]  devhead_r;
    logic [7:0]  apm_r;
    logic [7:0]  err_r;
    logic        err_flag_r;
    logic        pend_dma_r;
    logic [7:0]  bufptr_r;
    logic [15:0] secbuf [0:`ASB_SECT_WORDS-1];
    logic [8:0]  total_r;
    logic [8:0]  done_r;
    logic [7:0]  wcnt_r;
    logic        sect_full_r;
    logic        lba_r;
    logic [27:0] cur_r;
    logic [27:0] last_r;
    logic [31:0] prdata_r;

    logic        setup;
    logic        access;
    logic        wr_acc;
    logic        rd_acc;
    logic        mapped;
    logic        idle;
    logic        cmd_wr;
    logic        stat_rd;
    logic        data_wr;
    logic        data_rd;
    logic        fin_set;
    logic        dma_take;
    logic [7:0]  status;
    logic [27:0] start_addr;

    assign setup   = psel && !penable;
    assign access  = psel && penable;
    assign wr_acc  = access && pwrite;
    assign rd_acc  = access && !pwrite;
    assign mapped  = (paddr[1:0] == 2'b00) && (paddr <= `ASB_OFF_APMTMO);
    assign idle    = (state_r == ASB_IDLE);
    assign cmd_wr  = wr_acc && (paddr == `ASB_OFF_CMDSTAT) && idle;
    assign stat_rd = rd_acc && (paddr == `ASB_OFF_CMDSTAT);
    assign data_wr = wr_acc && (paddr == `ASB_OFF_DATA) && (state_r == ASB_PIO_WR);
    assign data_rd = rd_acc && (paddr == `ASB_OFF_DATA) && (state_r == ASB_PIO_RD);
    assign fin_set = (state_r == ASB_DONE);

    // ================================================================
    // APB slave, zero wait states
    assign pready  = 1'b1;
    assign pslverr = access && !mapped;
    assign prdata  = prdata_r;

    assign status = {!idle && !fin_set,
                     1'b1, 1'b0, spindle_run && spindle_at_speed,
                     (state_r == ASB_PIO_WR) || (state_r == ASB_PIO_RD),
                     2'b00, err_flag_r};

    // Read data captured in the setup phase, valid in the access phase
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            prdata_r <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            case (paddr)
                `ASB_OFF_DATA:    prdata_r <= {16'h0000, secbuf[bufptr_r]};
                `ASB_OFF_ERRFEAT: prdata_r <= {24'h00_0000, err_r};
                `ASB_OFF_SECCNT:  prdata_r <= {24'h00_0000, seccnt_r};
                `ASB_OFF_SECNUM:  prdata_r <= {24'h00_0000, secnum_r};
                `ASB_OFF_CYLLO:   prdata_r <= {24'h00_0000, cyllo_r};
                `ASB_OFF_CYLHI:   prdata_r <= {24'h00_0000, cylhi_r};
                `ASB_OFF_DEVHEAD: prdata_r <= {24'h00_0000, devhead_r};
                `ASB_OFF_CMDSTAT: prdata_r <= {24'h00_0000, status};
                `ASB_OFF_APMTMO:  prdata_r <= {24'h00_0000, apm_r};
                default:          prdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // ================================================================
    // Address arithmetic
    // Same packing for both modes; only the increment differs
    assign start_addr = {devhead_r[3:0], cylhi_r, cyllo_r, secnum_r};

    // CHS packs as head, cylinder, sector in the same 28 bits as LBA
    function automatic logic [27:0] next_addr(input logic [27:0] a, input logic lba);
        logic [27:0] n;
        n = a + 28'h000_0001;
        if (!lba) begin
            n = a;
            if (a[7:0] < `ASB_CHS_SPT) begin
                n[7:0] = a[7:0] + 8'h01;
            end else begin
                n[7:0] = 8'h01;
                if (a[27:24] < `ASB_CHS_HEADS) begin
                    n[27:24] = a[27:24] + 4'h1;
                end else begin
                    n[27:24] = 4'h0;
                    n[23:8]  = a[23:8] + 16'h0001;
                end
            end
        end
        next_addr = n;
    endfunction : next_addr

    // ================================================================
    // Two-entry buffer between DMA intake and media
    logic [15:0] fifo_d [0:1];
    logic        fifo_wp_r;
    logic        fifo_rp_r;
    logic [1:0]  fifo_cnt_r;
    logic        fifo_in_ready;
    logic        fifo_push;
    logic        fifo_pop;

    assign fifo_in_ready = (fifo_cnt_r != 2'd2);
    assign media_valid   = (fifo_cnt_r != 2'd0);
    assign media_data    = fifo_d[fifo_rp_r];
    assign fifo_push     = dma_take;
    assign fifo_pop      = media_valid && media_ready;

    always_ff @(posedge core_clk) begin
        if (fifo_push) begin
            fifo_d[fifo_wp_r] <= dma_wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            fifo_wp_r  <= 1'b0;
            fifo_rp_r  <= 1'b0;
            fifo_cnt_r <= 2'd0;
        end else begin
            if (fifo_push) begin
                fifo_wp_r <= !fifo_wp_r;
            end
            if (fifo_pop) begin
                fifo_rp_r <= !fifo_rp_r;
            end
            fifo_cnt_r <= fifo_cnt_r + {1'b0, fifo_push} - {1'b0, fifo_pop};
        end
    end

    // ================================================================
    // DMA request; stalls while the buffer is full
    assign dmarq    = (state_r == ASB_DMA_XFER) && !sect_full_r && fifo_in_ready;
    assign dma_take = dmarq && dmack;

    // ================================================================
    // Task-file registers written by software or loaded at completion
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            feat_r    <= 8'h00;
            seccnt_r  <= 8'h00;
            secnum_r  <= 8'h00;
            cyllo_r   <= 8'h00;
            cylhi_r   <= 8'h00;
            devhead_r <= `ASB_DH_RST;
            apm_r     <= `ASB_APM_RST;
        end else if (wr_acc && idle) begin
            case (paddr)
                `ASB_OFF_ERRFEAT: feat_r    <= pwdata[7:0];
                `ASB_OFF_SECCNT:  seccnt_r  <= pwdata[7:0];
                `ASB_OFF_SECNUM:  secnum_r  <= pwdata[7:0];
                `ASB_OFF_CYLLO:   cyllo_r   <= pwdata[7:0];
                `ASB_OFF_CYLHI:   cylhi_r   <= pwdata[7:0];
                `ASB_OFF_DEVHEAD: devhead_r <= pwdata[7:0];
                `ASB_OFF_APMTMO:  apm_r     <= pwdata[7:0];   // Only software alters it
                default: ;
            endcase
        end else if (fin_set && pend_dma_r) begin
            seccnt_r <= 8'(total_r - done_r);
            if (done_r != 9'd0) begin
                secnum_r  <= last_r[7:0];
                cyllo_r   <= last_r[15:8];
                cylhi_r   <= last_r[23:16];
                devhead_r <= {devhead_r[7:4], last_r[27:24]};
            end
        end
    end

    // ================================================================
    // Command sequencer
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_r    <= ASB_IDLE;
            pend_dma_r <= 1'b0;
            err_r      <= 8'h00;
            err_flag_r <= 1'b0;
            total_r    <= 9'd0;
            done_r     <= 9'd0;
            lba_r      <= 1'b0;
            cur_r      <= 28'h000_0000;
            last_r     <= 28'h000_0000;
        end else begin
            case (state_r)
                ASB_IDLE: begin
                    if (cmd_wr) begin
                        err_r      <= 8'h00;
                        err_flag_r <= 1'b0;
                        pend_dma_r <= 1'b0;
                        if (pwdata[7:0] == `ASB_OP_STBY_IMM_A || pwdata[7:0] == `ASB_OP_STBY_IMM_B) begin
                            state_r <= ASB_DONE;
                        end else if (pwdata[7:0] == `ASB_OP_BUF_WR) begin
                            state_r <= ASB_PIO_WR;
                        end else if (pwdata[7:0] == `ASB_OP_BUF_RD) begin
                            state_r <= ASB_PIO_RD;
                        end else if (pwdata[7:1] == `ASB_OP_DMA_WR) begin
                            pend_dma_r <= 1'b1;
                            total_r    <= (seccnt_r == 8'h00) ? 9'd256 : {1'b0, seccnt_r};
                            done_r     <= 9'd0;
                            lba_r      <= devhead_r[`ASB_DH_LBA];
                            cur_r      <= start_addr;
                            state_r    <= ASB_SPINUP;
                        end else begin
                            err_r[`ASB_ER_ABT] <= 1'b1;
                            err_flag_r         <= 1'b1;
                            state_r            <= ASB_DONE;
                        end
                    end
                end
                ASB_SPINUP: begin
                    if (spindle_run && spindle_at_speed) begin
                        state_r <= ASB_DMA_XFER;
                    end
                end
                ASB_PIO_WR: begin
                    if (data_wr && bufptr_r == 8'hFF) begin
                        state_r <= ASB_DONE;
                    end
                end
                ASB_PIO_RD: begin
                    if (data_rd && bufptr_r == 8'hFF) begin
                        state_r <= ASB_DONE;
                    end
                end
                ASB_DMA_XFER: begin
                    if (sect_full_r) begin
                        state_r <= ASB_DMA_SECT;
                    end
                end
                ASB_DMA_SECT: begin
                    if (media_sect_done) begin
                        if (media_unc) begin
                            err_r[`ASB_ER_IDN] <= 1'b1;
                            err_flag_r         <= 1'b1;
                            state_r            <= ASB_DONE;
                        end else begin
                            done_r  <= done_r + 9'd1;
                            last_r  <= cur_r;
                            cur_r   <= next_addr(cur_r, lba_r);
                            state_r <= (done_r + 9'd1 == total_r) ? ASB_DONE : ASB_DMA_XFER;
                        end
                    end
                end
                ASB_DONE: begin
                    state_r <= ASB_IDLE;
                end
                default: begin
                    state_r <= ASB_IDLE;
                end
            endcase
        end
    end

    // ================================================================
    // Sector buffer; one pointer serves write then read of the same sector
    always_ff @(posedge core_clk) begin
        if (data_wr) begin
            secbuf[bufptr_r] <= pwdata[15:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            bufptr_r <= 8'h00;
        end else if (cmd_wr) begin
            bufptr_r <= 8'h00;
        end else if (data_wr || data_rd) begin
            bufptr_r <= bufptr_r + 8'h01;
        end
    end

    // ================================================================
    // Word count within the current DMA sector
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wcnt_r      <= 8'h00;
            sect_full_r <= 1'b0;
        end else if (state_r == ASB_DMA_SECT || idle) begin
            wcnt_r      <= 8'h00;
            sect_full_r <= 1'b0;
        end else if (dma_take) begin
            wcnt_r <= wcnt_r + 8'h01;
            if (wcnt_r == 8'hFF) begin
                sect_full_r <= 1'b1;
            end
        end
    end

    // ================================================================
    // Spindle control
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            spindle_run <= 1'b1;
        end else if (cmd_wr && (pwdata[7:0] == `ASB_OP_STBY_IMM_A || pwdata[7:0] == `ASB_OP_STBY_IMM_B)) begin
            spindle_run <= 1'b0;   // Clearing an already clear level skips spin-down
        end else if (state_r == ASB_SPINUP) begin
            spindle_run <= 1'b1;
        end
    end

    // ================================================================
    // Completion interrupt; a new completion wins over a status read
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            intrq <= 1'b0;
        end else if (fin_set) begin
            intrq <= 1'b1;
        end else if (stat_rd) begin
            intrq <= 1'b0;
        end
    end

endmodule : asb_cmd

// ---- testbench/asb_cmd_monitor.sv ----
// Port-level checker for the command block
`timescale 1ns/100ps
module asb_cmd_monitor (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        rst_n,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // DMA, spindle, media
    input wire logic        dmarq,
    input wire logic        dmack,
    input wire logic        intrq,
    input wire logic        spindle_run,
    input wire logic        spindle_at_speed,
    input wire logic        media_valid,
    input wire logic        media_ready,
    input wire logic [15:0] media_data
);
    logic acc;
    logic bad_adr;
    logic stby_wr;
    assign acc     = psel && penable;
    assign bad_adr = (paddr > 8'h20) || (paddr[1:0] != 2'h0);
    assign stby_wr = acc && pwrite && paddr == 8'h1C && (pwdata[7:0] == 8'hE0 || pwdata[7:0] == 8'h94);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // ====================================
    // Assertions
    a_dmarq_at_speed: assert property (dmarq |-> spindle_run && spindle_at_speed)
        else $error("dma request before spin-up");
    // Spin-down lands one or two edges after the opcode
    a_spin_down_cause: assert property ($fell(spindle_run) |-> $past(stby_wr) || $past(stby_wr, 2))
        else $error("spindle stopped without standby");
    a_push_to_media: assert property (dmarq && dmack |=> media_valid)
        else $error("dma word not buffered");
    a_media_hold: assert property (media_valid && !media_ready |=> media_valid && $stable(media_data))
        else $error("media word lost in stall");
    a_intrq_quiet: assert property ($rose(intrq) |-> !dmarq && !media_valid)
        else $error("interrupt before transfer end");
    a_access_ready: assert property (acc |-> pready)
        else $error("access without ready");
    a_slverr_cause: assert property (pslverr |-> acc && bad_adr)
        else $error("error on mapped access");
    a_bad_addr: assert property (acc && bad_adr && !pwrite |-> pslverr && prdata == 32'h0)
        else $error("unmapped read not refused");
    a_reset_state: assert property ($rose(rst_n) |-> spindle_run && !intrq && !dmarq && !media_valid)
        else $error("bad state after reset");
    c_standby: cover property (stby_wr);
    c_dma_word: cover property (dmarq && dmack);
    c_irq: cover property ($rose(intrq));
endmodule : asb_cmd_monitor

bind asb_cmd asb_cmd_monitor mon (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .dmarq, .dmack, .intrq, .spindle_run, .spindle_at_speed, .media_valid,
    .media_ready, .media_data);

// ---- testbench/asb_host_dma.sv ----
// Host slave-DMA channel model, prompt or slow
`timescale 1ns/100ps
module asb_host_dma (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        rst_n,
    // Pace: 0 prompt, 3 stalls most
    input wire logic [1:0]  slow,
    // DMA channel
    input wire logic        dmarq,
    output logic            dmack,
    output logic     [15:0] dma_wdata
);
    logic go;
    // Channel armed from reset, before any opcode
    always @(posedge core_clk) begin
        go = ($urandom % 4) >= slow;
        if (!rst_n) begin
            dmack     <= 1'b0;
            dma_wdata <= 16'h0;
        end else if (!dmack || dmarq) begin
            // Idle data toggles so a stale word never looks valid
            dmack     <= go;
            dma_wdata <= go ? 16'($urandom) : ~dma_wdata;
        end
    end
endmodule : asb_host_dma

// ---- testbench/test_ata_standby_buffer_dma_write.sv ----
// Self-checking bench for the command block
`timescale 1ns/100ps
module test_ata_standby_buffer_dma_write;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic        pready, pslverr, s, dmarq, dmack, intrq, spindle_run, int_d = 1'b0;
    logic        at_spd = 1'b0, media_ready = 1'b0, done = 1'b0, unc = 1'b0, unc_on = 1'b0;
    logic        media_valid;
    logic [15:0] dma_wdata, media_data;
    logic [1:0]  slow = 2'h0;
    logic [15:0] exp_q[$], buf_q[$];
    int          miscompares = 0, checks_done = 0, wcnt = 0, words = 0, ints = 0, sp = 0;

    always #4 core_clk = ~core_clk;

    asb_cmd dut (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .dmarq, .dmack, .dma_wdata, .intrq, .spindle_run, .spindle_at_speed(at_spd),
        .media_valid, .media_ready, .media_data, .media_sect_done(done), .media_unc(unc));
    asb_host_dma host (.core_clk, .rst_n, .slow, .dmarq, .dmack, .dma_wdata);

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize

    // ====================================
    // APB master; request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        q = prdata;
        s = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rd

    task automatic fin(input logic [7:0] st);
        for (int i = 0; i < 30000 && intrq !== 1'b1; i++) @(negedge core_clk);
        @(negedge core_clk);
        chk(ints, 1);
        ints = 0;
        rd(8'h1C, {24'h0, st});
        @(negedge core_clk);
        chk(intrq, 1'b0);
    endtask : fin

    task automatic dma(input logic [7:0] op, input logic [7:0] cnt, input logic [31:0] a,
                       input logic lba, input logic [7:0] st, input int n);
        apb(1'b1, 8'h08, {24'h0, cnt});
        for (int i = 0; i < 3; i++) apb(1'b1, 8'h0C + 8'(4 * i), {24'h0, a[8*i +: 8]});
        apb(1'b1, 8'h18, {24'h0, 1'b1, lba, 2'b10, a[27:24]});
        apb(1'b1, 8'h1C, {24'h0, op});
        apb(1'b0, 8'h1C, 32'h0);
        chk(q[7], 1'b1);
        fin(st);
        chk(words, n);
        chk(exp_q.size(), 0);
        words = 0;
    endtask : dma

    task automatic res(input logic [7:0] cnt, input logic [31:0] e);
        rd(8'h08, {24'h0, cnt});
        for (int i = 0; i < 3; i++) rd(8'h0C + 8'(4 * i), {24'h0, e[8*i +: 8]});
        apb(1'b0, 8'h18, 32'h0);
        chk(q[3:0], e[27:24]);
    endtask : res

    // ====================================
    // Watchers: DMA notes, media sink, spindle
    always @(posedge core_clk) begin
        if (intrq && !int_d) ints++;
        int_d <= intrq;
        if (rst_n && dmarq && dmack) exp_q.push_back(dma_wdata);
    end

    always @(posedge core_clk) begin
        media_ready <= ($urandom % 4) != 0;
        done        <= 1'b0;
        sp = spindle_run ? sp + 1 : 0;
        at_spd      <= sp > 20;
        if (media_valid && media_ready) begin
            chk(media_data, exp_q.pop_front());
            words++;
            wcnt++;
            if (wcnt == 256) begin
                wcnt = 0;
                done <= 1'b1;
                unc  <= unc_on;
            end
        end
    end

    initial begin
        #400000;
        miscompares++;
        summarize();
    end

    initial begin
        void'($urandom(32'h40353092));
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (30) @(posedge core_clk);
        rd(8'h1C, 32'h50);
        rd(8'h18, 32'hA0);
        rd(8'h20, 32'h0);
        for (int i = 0; i < 2; i++) begin
            rd(i ? 8'h24 : 8'h02, 32'h0);
            chk(s, 1'b1);
        end
        apb(1'b1, 8'h1C, 32'h0);
        fin(8'h51);
        rd(8'h04, 32'h04);
        $display("test reset and abort done");
        apb(1'b1, 8'h1C, 32'hE8);
        do apb(1'b0, 8'h1C, 32'h0); while (q[3] !== 1'b1);
        for (int i = 0; i < 256; i++) begin
            buf_q.push_back(16'($urandom));
            apb(1'b1, 8'h00, {16'h0, buf_q[i]});
        end
        fin(8'h50);
        // Stray word after the sector must not land
        apb(1'b1, 8'h00, 32'hFFFF);
        apb(1'b1, 8'h1C, 32'hE4);
        do apb(1'b0, 8'h1C, 32'h0); while (q[3] !== 1'b1);
        for (int i = 0; i < 256; i++) rd(8'h00, {16'h0, buf_q[i]});
        fin(8'h50);
        $display("test buffer done");
        apb(1'b1, 8'h20, 32'h5A);
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, 8'h1C, i ? 32'h94 : 32'hE0);
            fin(8'h40);
            chk(spindle_run, 1'b0);
        end
        rd(8'h20, 32'h5A);
        $display("test standby done");
        slow <= 2'h2;
        dma(8'hCB, 8'h02, 32'h0ABCDEFF, 1'b1, 8'h50, 512);
        res(8'h00, 32'h0ABCDF00);
        slow <= 2'h0;
        dma(8'hCA, 8'h02, 32'h0000053F, 1'b0, 8'h50, 512);
        res(8'h00, 32'h01000501);
        unc_on = 1'b1;
        dma(8'hCA, 8'h00, 32'h00000101, 1'b0, 8'h51, 256);
        rd(8'h04, 32'h10);
        rd(8'h08, 32'h00);
        $display("test dma done");
        summarize();
    end
endmodule : test_ata_standby_buffer_dma_write
